// [rtl/hbmi_host_port.sv]
`timescale 1ns/1ps
// Function
// (RL1) A high multiplex strap makes the host port a multiplexed bus.
// (RL2) With the multiplex strap low, the style input picks strobe or ack.
// (RL3) The host drives address bits 10..8 on the upper address lines.
// (RL4) Shared lines carry the low address byte, then the data byte.
// (RL5) Accesses are taken only while the active-low select is low.
// (RL6) A read strobe with select drives the addressed byte out.
// (RL7) A write strobe with select stores the shared byte at the address.
// (RL8) The latch enable phase fixes the address for the whole access.
// (RL9) Ready is high when the access can complete, low for waits.
// (RL10) A pending interrupt is shown on the interrupt output.
// (RL11) The polarity strap sets the interrupt output's asserted level.
// (RL12) The low address byte is caught on the latch enable falling edge.
// (RL13) Ready and data are driven only while selected, data only on reads.
module hbmi_host_port
  import hbmi_pkg::*;
#(
  parameter int AW = hbmi_pkg::ADDR_W,
  parameter int DW = hbmi_pkg::DATA_W
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Mode straps.
  input wire logic mux_mode_select,
  input wire logic split_bus_style_select,
  input wire logic interrupt_polarity_select,
  // Host bus pins.
  input wire logic [hbmi_pkg::UPPER_W-1:0] upper_address_lines,
  input wire logic [hbmi_pkg::DATA_W-1:0] shared_address_data_lines_i,
  output logic [hbmi_pkg::DATA_W-1:0] shared_address_data_lines_o,
  output logic shared_address_data_lines_oe,
  input wire logic select_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic addr_latch_en,
  output logic ready_o,
  output logic ready_oe,
  output logic interrupt_o,
  output logic interrupt_oe,
  // Internal memory map side.
  output logic [hbmi_pkg::ADDR_W-1:0] mem_addr,
  output logic [hbmi_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_rd,
  output logic mem_wr,
  input wire logic mem_ack,
  input wire logic [hbmi_pkg::DATA_W-1:0] mem_rdata,
  input wire logic irq_pending,
  // Active style, for the rest of the device.
  output hbmi_pkg::hbmi_style_t style
);
  import hbmi_pkg::*;

  localparam int PW = 6 + UPPER_W + DATA_W;
  localparam logic [PW-1:0] PIN_RST = {6'b111000, {(PW-6){1'b0}}};

  logic [PW-1:0] pins_s;
  logic sel_n_s, rd_n_s, wr_n_s, ale_s, mux_s, sty_s;
  logic [UPPER_W-1:0] upa_s;
  logic [DATA_W-1:0] ad_s;

  // Every host pin is asynchronous, so all pass two flops first.
  hbmi_sync #(.W(PW), .RST_VAL(PIN_RST)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in({select_n, read_n, write_n, addr_latch_en, mux_mode_select,
      split_bus_style_select, upper_address_lines,
      shared_address_data_lines_i}),
    .sync_out(pins_s)
  );
  assign {sel_n_s, rd_n_s, wr_n_s, ale_s, mux_s, sty_s, upa_s, ad_s} = pins_s;

  // The polarity strap is a pin as well; it resets to the high sense.
  logic pol_s;
  hbmi_sync #(.W(1), .RST_VAL(1'b1)) u_sync_pol (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(interrupt_polarity_select),
    .sync_out(pol_s)
  );

  hbmi_state_t state_q, state_d;
  logic ale_q, ale_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdata_q, wdata_d;
  logic [DW-1:0] rdata_q, rdata_d;
  logic is_rd_q, is_rd_d;
  logic rdy_q, rdy_d;
  hbmi_style_t style_q, style_d;
  logic pol_q, pol_d;
  logic irq_q, irq_d;

  // Straps are sampled every cycle; the polarity pin is only a level.
  always_comb begin
    if (mux_s) begin
      style_d = HBMI_STYLE_MUX; // [RL1]
    end else if (sty_s) begin
      style_d = HBMI_STYLE_ACK; // [RL2]
    end else begin
      style_d = HBMI_STYLE_STROBE; // [RL2]
    end
    pol_d = pol_s; // [RL11]
    irq_d = irq_pending;
  end

  // Address capture and access sequencing.
  // The address is held from the falling latch edge, so a strobe that
  // arrives while the shared lines already carry data still uses it.
  always_comb begin
    state_d = state_q;
    ale_d = ale_s;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    is_rd_d = is_rd_q;
    rdy_d = rdy_q;
    if (ale_q && !ale_s) begin
      addr_d = {upa_s, ad_s}; // [RL3] [RL4] [RL8] [RL12]
    end
    case (state_q)
      HBMI_IDLE: begin
        rdy_d = 1'b1;
        if (!sel_n_s && !ale_s && (!rd_n_s || !wr_n_s)) begin // [RL5]
          is_rd_d = !rd_n_s; // [RL6]
          wdata_d = ad_s; // [RL7]
          rdy_d = 1'b0; // [RL9]
          state_d = HBMI_REQ;
        end
      end
      HBMI_REQ: begin
        state_d = HBMI_WAIT;
      end
      HBMI_WAIT: begin
        if (mem_ack) begin
          if (is_rd_q) begin
            rdata_d = mem_rdata; // [RL6]
          end
          rdy_d = 1'b1; // [RL9]
          state_d = HBMI_DONE;
        end
      end
      HBMI_DONE: begin
        // Wait for the strobe or select to end before the next access.
        if (sel_n_s || (rd_n_s && wr_n_s)) begin
          state_d = HBMI_IDLE;
        end
      end
      default: begin
        state_d = HBMI_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= HBMI_IDLE;
      ale_q <= 1'b0;
      addr_q <= ADDR_RST;
      wdata_q <= DATA_RST;
      rdata_q <= DATA_RST;
      is_rd_q <= 1'b0;
      rdy_q <= 1'b1;
      style_q <= HBMI_STYLE_STROBE;
      pol_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ale_q <= ale_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      is_rd_q <= is_rd_d;
      rdy_q <= rdy_d;
      style_q <= style_d;
      pol_q <= pol_d;
      irq_q <= irq_d;
    end
  end

  // Memory side requests last one cycle in the request state.
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign mem_rd = (state_q == HBMI_REQ) && is_rd_q;
  assign mem_wr = (state_q == HBMI_REQ) && !is_rd_q; // [RL7]
  assign style = style_q;

  // Pin drivers: ready and data are released whenever the host does not select the device.
  // The combinational enables use synchronised pins, so release lags the
  // host by two cycles; hosts must allow that turnaround.
  assign ready_o = rdy_q; // [RL9]
  assign ready_oe = !sel_n_s; // [RL13]
  assign shared_address_data_lines_o = rdata_q;
  assign shared_address_data_lines_oe = !sel_n_s && !rd_n_s
    && is_rd_q && (state_q == HBMI_DONE); // [RL6] [RL13]
  // Asserted level follows the strap; the pin is always driven.
  assign interrupt_o = pol_q ? irq_q : !irq_q; // [RL10] [RL11]
  assign interrupt_oe = 1'b1;
endmodule

// [rtl/hbmi_pkg.sv]
package hbmi_pkg;
  // Address layout of the host port.
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int UPPER_W = 3;
  localparam int UPPER_LSB = 8;
  // Host port styles chosen by the straps.
  typedef enum logic [1:0] {
    HBMI_STYLE_MUX = 2'b00,
    HBMI_STYLE_STROBE = 2'b01,
    HBMI_STYLE_ACK = 2'b11
  } hbmi_style_t;
  // Access sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    HBMI_IDLE = 2'b00,
    HBMI_REQ = 2'b01,
    HBMI_WAIT = 2'b11,
    HBMI_DONE = 2'b10
  } hbmi_state_t;
  // Reset values.
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
endpackage

// [rtl/hbmi_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of asynchronous pin levels.
module hbmi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Levels.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Both stages take their reset constant asynchronously.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// [verification/hbmi_chk_checker.sv]
`timescale 1ns/1ps
// Straps are only judged after they have been steady long enough to settle.
module hbmi_chk
  import hbmi_pkg::*;
(
  input wire logic ref_clk, reset, mux_mode_select, split_bus_style_select,
  input wire logic interrupt_polarity_select, irq_pending, interrupt_o,
  input wire logic interrupt_oe, select_n, read_n, ready_o, ready_oe,
  input wire logic shared_address_data_lines_oe, mem_rd, mem_wr, mem_ack,
  input hbmi_pkg::hbmi_style_t style
);
  wire mux = mux_mode_select;
  wire spl = split_bus_style_select;
  wire pol = interrupt_polarity_select;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_irq_level: assert property (($stable(pol) &&
    $stable(irq_pending))[*4] |-> interrupt_o == (irq_pending ~^ pol))
    else $error("interrupt level wrong");
  chk_irq_drive: assert property (interrupt_oe)
    else $error("interrupt not driven");
  chk_style_mux: assert property (mux[*4] |-> style == HBMI_STYLE_MUX)
    else $error("style not mux");
  chk_style_split: assert property ((!mux && $stable(spl))[*4] |->
    style == (spl ? HBMI_STYLE_ACK : HBMI_STYLE_STROBE))
    else $error("split style wrong");
  chk_ready_hold: assert property (!ready_o && !mem_ack |=> !ready_o)
    else $error("ready rose early");
  chk_ready_rise: assert property (!ready_o && mem_ack |=> ready_o)
    else $error("ready stuck low");
  chk_no_select: assert property (select_n[*5] |-> !mem_rd && !mem_wr)
    else $error("access while deselected");
  chk_data_oe: assert property (shared_address_data_lines_oe |->
    !$past(select_n, 2) && !$past(read_n, 2))
    else $error("data driven off read");
  chk_ready_oe: assert property (ready_oe == !$past(select_n, 2))
    else $error("ready enable wrong");
endmodule
bind hbmi_host_port hbmi_chk i_chk (.*);

// [verification/hbmi_host_model.sv]
`timescale 1ns/1ps
// Host side of the multiplexed bus; its pins move on the falling edge.
module hbmi_host_model
  import hbmi_pkg::*;
(
  input wire logic ref_clk, ready_o, shared_address_data_lines_oe,
  input wire logic [DATA_W-1:0] shared_address_data_lines_o,
  output logic [DATA_W-1:0] shared_address_data_lines_i,
  output logic [UPPER_W-1:0] upper_address_lines,
  output logic select_n, read_n, write_n, addr_latch_en
);
  logic [DATA_W-1:0] drv = 8'h00;
  logic en = 1'b0;
  // A released bus shows the inverse of the last value, never a held copy.
  assign shared_address_data_lines_i = shared_address_data_lines_oe ?
    shared_address_data_lines_o : (en ? drv : ~drv);
  initial {select_n, read_n, write_n, addr_latch_en} = 4'he;
  initial upper_address_lines = 3'h0;
  // Address phase, strobe, then wait states until ready is high.
  task automatic access(input logic wr, sel, input logic [10:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    upper_address_lines = a[10:8];
    drv = a[7:0];
    en = 1'b1;
    addr_latch_en = 1'b1;
    repeat (4) @(negedge ref_clk);
    addr_latch_en = 1'b0;
    repeat (4) @(negedge ref_clk);
    drv = d;
    en = wr;
    {select_n, read_n, write_n} = {!sel, wr, !wr};
    repeat (4) @(negedge ref_clk);
    n = 0;
    while (ready_o !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    q = shared_address_data_lines_i;
    {select_n, read_n, write_n, en} = 4'he;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule

// [verification/host_bus_mux_interface_bench.sv]
`timescale 1ns/1ps
// Bench drives straps, interrupt and internal memory; the host model the bus.
module host_bus_mux_interface_bench;
  import hbmi_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, mux_mode_select = 1'b1;
  logic split_bus_style_select = 1'b0, interrupt_polarity_select = 1'b1;
  logic irq_pending = 1'b0, mem_ack = 1'b0, mem_rd, mem_wr, ready_o;
  logic ready_oe, interrupt_o, interrupt_oe, shared_address_data_lines_oe;
  logic select_n, read_n, write_n, addr_latch_en;
  logic [2:0] upper_address_lines;
  logic [7:0] shared_address_data_lines_i, shared_address_data_lines_o;
  logic [7:0] mem_wdata, mem_rdata = 8'h00, q, d, mem[2048], exp[2048];
  logic [10:0] mem_addr, a;
  hbmi_style_t style;
  int error_cnt = 0, total_checks = 0, seed = 32'h49a8, lat = 0, acc = 0;
  int acc0;
  hbmi_host_port i_dut (.*);
  hbmi_host_model i_host (.*);
  always #2 ref_clk = ~ref_clk;
  // Memory answers one to four cycles after each pulse.
  always @(negedge ref_clk) begin
    mem_ack <= lat == 1;
    if (lat > 0) lat <= lat - 1;
    if (mem_rd || mem_wr) begin
      lat <= 1 + ($random(seed) & 3);
      acc <= acc + 1;
      mem_rdata <= mem[mem_addr];
      if (mem_wr) mem[mem_addr] <= mem_wdata;
    end
  end
  function automatic logic [7:0] pat(input logic [10:0] x);
    return x[7:0] ^ {x[10:8], x[10:8], 2'b01};
  endfunction
  task automatic cmp(input string what, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #40000;
    error_cnt++;
    end_of_test();
  end
  // Reads prove the address only in part, since 2048 locations share 256 start values.
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = pat(i[10:0]);
      exp[i] = mem[i];
    end
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    cmp("style", {6'h0, HBMI_STYLE_MUX}, {6'h0, style});
    for (int i = 0; i < 10; i++) begin
      a = i == 0 ? 11'h7ff : i == 1 ? 11'h000 : 11'($random(seed));
      d = 8'($random(seed));
      i_host.access(1'b0, 1'b1, a, d, q);
      cmp("read", exp[a], q);
      i_host.access(1'b1, 1'b1, a, d, q);
      i_host.access(1'b0, 1'b1, a, ~d, q);
      cmp("readback", d, q);
      exp[a] = d;
    end
    $display("test access done");
    acc0 = acc;
    i_host.access(1'b1, 1'b0, 11'h005, 8'h5a, q);
    cmp("accesses", 8'(acc0), 8'(acc));
    i_host.access(1'b0, 1'b1, 11'h005, 8'h00, q);
    cmp("kept", exp[5], q);
    $display("test select done");
    for (int i = 0; i < 8; i++) begin
      {interrupt_polarity_select, irq_pending} =
        i < 4 ? i[1:0] : 2'($random(seed));
      repeat (4) @(negedge ref_clk);
      cmp("irq", {7'h0, irq_pending ~^ interrupt_polarity_select},
        {7'h0, interrupt_o});
    end
    $display("test irq done");
    mux_mode_select = 1'b0;
    for (int i = 0; i < 2; i++) begin
      split_bus_style_select = i[0];
      repeat (5) @(negedge ref_clk);
      cmp("style", {6'h0, i ? HBMI_STYLE_ACK : HBMI_STYLE_STROBE},
        {6'h0, style});
    end
    $display("test style done");
    end_of_test();
  end
endmodule
